// file: rtl/adc_seq_window_pkg.sv
package adc_seq_window_pkg;

  // register byte offsets
  localparam logic [7:0] OFFS_HIGH_THRESHOLD = 8'h14;
  localparam logic [7:0] OFFS_LOW_THRESHOLD  = 8'h18;
  localparam logic [7:0] OFFS_SLOTS_LOW      = 8'h50;
  localparam logic [7:0] OFFS_SLOTS_HIGH     = 8'h54;
  localparam logic [7:0] OFFS_SEQ_CONTROL    = 8'h60;
  localparam logic [7:0] OFFS_IRQ_STATUS     = 8'h64;
  localparam logic [7:0] OFFS_IRQ_MASK       = 8'h68;
  localparam logic [7:0] OFFS_SEQ_STATUS     = 8'h6C;

  // field layout
  localparam int CHANNEL_WIDTH       = 4;
  localparam int SLOTS_PER_REG       = 4;
  localparam int SLOT_COUNT          = 8;
  localparam int LENGTH_LSB          = 16;
  localparam int LENGTH_WIDTH        = 3;
  localparam int THRESHOLD_WIDTH     = 12;
  localparam int SLOTS_LOW_USED      = 19;
  localparam int SLOTS_HIGH_USED     = 16;

  // reset values
  localparam logic [11:0] HIGH_THRESHOLD_RESET = 12'hFFF;
  localparam logic [11:0] LOW_THRESHOLD_RESET  = 12'h000;
  localparam logic [18:0] SLOTS_LOW_RESET      = 19'h00000;
  localparam logic [15:0] SLOTS_HIGH_RESET     = 16'h0000;

  // channel codes
  localparam logic [3:0] CHANNEL_LAST_EXTERNAL = 4'hC;
  localparam logic [3:0] CHANNEL_SUPPLY_THIRD  = 4'hD;
  localparam logic [3:0] CHANNEL_TEMPERATURE   = 4'hE;
  localparam logic [3:0] CHANNEL_CORE_REF      = 4'hF;

  // interrupt status bits
  localparam int IRQ_BIT_IN_WINDOW = 0;
  localparam int IRQ_BIT_ABOVE     = 1;
  localparam int IRQ_BIT_BELOW     = 2;
  localparam int IRQ_BIT_SEQ_DONE  = 3;
  localparam int IRQ_WIDTH         = 4;

  // sequence control bits
  localparam int CTRL_BIT_START = 0;
  localparam int CTRL_BIT_ABORT = 1;

  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_SELECT  = 2'b01,
    SEQ_CONVERT = 2'b10,
    SEQ_NEXT    = 2'b11
  } seq_state_type;

endpackage : adc_seq_window_pkg

// file: rtl/adc_sequence_and_window_cfg.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps

// Contract
// - length field n scans slots zero through n
// - slot zero bits 3:0, codes 0-12 external
// - codes 13/14/15 supply third, temperature, reference
// - slots one-three at bits 7:4, 11:8, 15:12
// - slot four bits 3:0 of second register
// - slots five-seven at 7:4, 11:8, 15:12
// - high threshold 12 bits, resets all ones
// - low threshold 12 bits, resets to zero
// - in window: low <= result < high
// - above: high <= result < 4096
// - below: result < low
module adc_sequence_and_window_cfg
  import adc_seq_window_pkg::*;
#(
  parameter int SETTLE_CYCLES = 2
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // converter core
  output logic      [3:0]            channel_select_o,
  output logic                       convert_start_o,
  input  wire logic                  convert_done_i,
  input  wire logic [11:0]           result_i,
  // watchdog flags and status
  output logic                       in_window_flag_o,
  output logic                       above_upper_flag_o,
  output logic                       below_lower_flag_o,
  output logic                       busy_o,
  output logic                       irq_o
);
  import adc_seq_window_pkg::*;

  // the settle counter is eight bits wide and must wait at least one cycle
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end
  // the two sequence registers each carry the same number of slot fields
  if (SLOT_COUNT != 2 * SLOTS_PER_REG) begin : g_bad_slots
    $error("slot count does not fit two sequence registers");
  end
  // threshold registers and the comparator are built for 12-bit results
  if (THRESHOLD_WIDTH != 12) begin : g_bad_threshold
    $error("threshold width must be 12");
  end
  // the sequence-done event needs its own status bit
  if (IRQ_BIT_SEQ_DONE >= IRQ_WIDTH) begin : g_bad_irq
    $error("status register too narrow");
  end

  logic [11:0]             upper_limit_value_reg;
  logic [11:0]             lower_limit_value_reg;
  logic [18:0]             slots_low_reg;
  logic [15:0]             slots_high_reg;
  logic [IRQ_WIDTH-1:0]    irq_status_reg;
  logic [IRQ_WIDTH-1:0]    irq_mask_reg;
  logic [IRQ_WIDTH-1:0]    irq_events;
  logic [31:0]             read_data_next;
  logic                    bus_req;
  logic                    wr_fire;
  logic [31:0]             wmask;
  logic                    start_req;
  logic                    abort_req;
  seq_state_type           state_reg;
  logic [2:0]              slot_index_reg;
  logic [7:0]              settle_count_reg;
  logic [3:0]              slot_channel [SLOT_COUNT];
  logic [2:0]              sequence_length_select;
  logic                    result_in_window;
  logic                    result_above;
  logic                    result_below;
  logic                    seq_done_pulse;
  logic                    wr_high_threshold;
  logic                    wr_low_threshold;
  logic                    wr_slots_low;
  logic                    wr_slots_high;
  logic                    wr_control;
  logic                    wr_irq_status;
  logic                    wr_irq_mask;
  logic                    rd_fire;

  // byte-enable mask built from sel
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // register select, shared by every write strobe
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
    reg_hit = (addr == offs);
  endfunction : reg_hit

  // merge a write into a narrow field starting at bit 0
  function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [31:0] mask);
    merge_word = (old_word & ~mask) | (new_word & mask);
  endfunction : merge_word

  // watchdog comparison, shared by the flags and the interrupt events
  function automatic logic [2:0] classify(input logic [11:0] value,
                                          input logic [11:0] low,
                                          input logic [11:0] high);
    classify[0] = (value >= low) && (value < high);
    classify[1] = (value >= high);
    classify[2] = (value < low);
  endfunction : classify

  assign bus_req  = cyc_i && stb_i;
  assign wr_fire  = bus_req && we_i && !ack_o;
  assign wmask    = lane_mask(sel_i);

  // one strobe per register; the byte-wide registers need lane 0 enabled
  assign wr_high_threshold = wr_fire && reg_hit(adr_i, OFFS_HIGH_THRESHOLD);
  assign wr_low_threshold  = wr_fire && reg_hit(adr_i, OFFS_LOW_THRESHOLD);
  assign wr_slots_low      = wr_fire && reg_hit(adr_i, OFFS_SLOTS_LOW);
  assign wr_slots_high     = wr_fire && reg_hit(adr_i, OFFS_SLOTS_HIGH);
  assign wr_control        = wr_fire && reg_hit(adr_i, OFFS_SEQ_CONTROL) && sel_i[0];
  assign wr_irq_status     = wr_fire && reg_hit(adr_i, OFFS_IRQ_STATUS) && sel_i[0];
  assign wr_irq_mask       = wr_fire && reg_hit(adr_i, OFFS_IRQ_MASK) && sel_i[0];
  assign rd_fire           = bus_req && !we_i && !ack_o;

  // one wait state per access, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req && !ack_o;
    end
  end

  // reserved bits 31:12 are dropped on write and read back zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_limit_value_reg <= HIGH_THRESHOLD_RESET;
    end else if (wr_high_threshold) begin
      upper_limit_value_reg <= 12'(merge_word({20'h00000, upper_limit_value_reg},
                                              dat_i, wmask));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lower_limit_value_reg <= LOW_THRESHOLD_RESET;
    end else if (wr_low_threshold) begin
      lower_limit_value_reg <= 12'(merge_word({20'h00000, lower_limit_value_reg},
                                              dat_i, wmask));
    end
  end

  // reserved bits 31:19 are not stored, so they read back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slots_low_reg <= SLOTS_LOW_RESET;
    end else if (wr_slots_low) begin
      slots_low_reg <= 19'(merge_word({13'h0000, slots_low_reg}, dat_i, wmask));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slots_high_reg <= SLOTS_HIGH_RESET;
    end else if (wr_slots_high) begin
      slots_high_reg <= 16'(merge_word({16'h0000, slots_high_reg}, dat_i, wmask));
    end
  end

  assign sequence_length_select = slots_low_reg[LENGTH_LSB +: LENGTH_WIDTH];

  // slot fields: four per register, same nibble layout in both
  genvar g;
  generate
    for (g = 0; g < SLOTS_PER_REG; g++) begin : g_slot
      assign slot_channel[g] = slots_low_reg[g*CHANNEL_WIDTH +: CHANNEL_WIDTH];
      assign slot_channel[g+SLOTS_PER_REG] =
        slots_high_reg[g*CHANNEL_WIDTH +: CHANNEL_WIDTH];
    end
  endgenerate

  assign start_req = wr_control && dat_i[CTRL_BIT_START];
  assign abort_req = wr_control && dat_i[CTRL_BIT_ABORT];

  // sequencer: channel is driven for SETTLE_CYCLES minus one cycles before the start pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg        <= SEQ_IDLE;
      slot_index_reg   <= 3'd0;
      settle_count_reg <= 8'd0;
    end else if (abort_req) begin
      state_reg <= SEQ_IDLE;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start_req) begin
            slot_index_reg   <= 3'd0;
            settle_count_reg <= 8'(SETTLE_CYCLES - 1);
            state_reg        <= SEQ_SELECT;
          end
        end
        SEQ_SELECT: begin
          if (settle_count_reg == 8'd0) begin
            state_reg <= SEQ_CONVERT;
          end else begin
            settle_count_reg <= settle_count_reg - 8'd1;
          end
        end
        SEQ_CONVERT: begin
          if (convert_done_i) begin
            state_reg <= SEQ_NEXT;
          end
        end
        SEQ_NEXT: begin
          if (slot_index_reg == sequence_length_select) begin
            state_reg <= SEQ_IDLE;
          end else begin
            slot_index_reg   <= slot_index_reg + 3'd1;
            settle_count_reg <= 8'(SETTLE_CYCLES - 1);
            state_reg        <= SEQ_SELECT;
          end
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // codes 0-12 external inputs, 13-15 internal sources, passed through as-is
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_select_o <= 4'h0;
    end else begin
      channel_select_o <= slot_channel[slot_index_reg];
    end
  end

  // start pulse raised once per slot on entry to the convert state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      convert_start_o <= 1'b0;
    end else begin
      convert_start_o <= (state_reg == SEQ_SELECT) && (settle_count_reg == 8'd0) &&
                         !abort_req;
    end
  end

  // busy comes straight from the state so software sees a start at once
  assign busy_o         = (state_reg != SEQ_IDLE);
  assign seq_done_pulse = (state_reg == SEQ_NEXT) &&
                          (slot_index_reg == sequence_length_select) && !abort_req;

  assign {result_below, result_above, result_in_window} =
    classify(result_i, lower_limit_value_reg, upper_limit_value_reg);

  // flags follow the latest result; a 12-bit value is always below 4096
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_window_flag_o   <= 1'b0;
      above_upper_flag_o <= 1'b0;
      below_lower_flag_o <= 1'b0;
    end else if (convert_done_i && state_reg == SEQ_CONVERT) begin
      in_window_flag_o   <= result_in_window;
      above_upper_flag_o <= result_above;
      below_lower_flag_o <= result_below;
    end
  end

  // events last one cycle; the status register keeps them
  always_comb begin
    irq_events                    = '0;
    irq_events[IRQ_BIT_IN_WINDOW] = convert_done_i && state_reg == SEQ_CONVERT &&
                                    result_in_window;
    irq_events[IRQ_BIT_ABOVE]     = convert_done_i && state_reg == SEQ_CONVERT &&
                                    result_above;
    irq_events[IRQ_BIT_BELOW]     = convert_done_i && state_reg == SEQ_CONVERT &&
                                    result_below;
    irq_events[IRQ_BIT_SEQ_DONE]  = seq_done_pulse;
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= '0;
    end else begin
      if (wr_irq_status) begin
        irq_status_reg <= (irq_status_reg & ~dat_i[IRQ_WIDTH-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  // the mask only gates the interrupt line, status still records events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= dat_i[IRQ_WIDTH-1:0];
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  always_comb begin
    read_data_next = 32'h00000000;
    case (adr_i)
      OFFS_HIGH_THRESHOLD: read_data_next = {20'h00000, upper_limit_value_reg};
      OFFS_LOW_THRESHOLD:  read_data_next = {20'h00000, lower_limit_value_reg};
      OFFS_SLOTS_LOW:      read_data_next = {13'h0000, slots_low_reg};
      OFFS_SLOTS_HIGH:     read_data_next = {16'h0000, slots_high_reg};
      OFFS_IRQ_STATUS:     read_data_next = {28'h0000000, irq_status_reg};
      OFFS_IRQ_MASK:       read_data_next = {28'h0000000, irq_mask_reg};
      OFFS_SEQ_STATUS:     read_data_next = {21'h000000, slot_index_reg, busy_o,
                                             below_lower_flag_o, above_upper_flag_o,
                                             in_window_flag_o, channel_select_o};
      default:             read_data_next = 32'h00000000;
    endcase
  end

  // read data is captured with the request so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd_fire) begin
      dat_o <= read_data_next;
    end
  end

endmodule : adc_sequence_and_window_cfg

// file: testbench/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control from the block; delay_i comes from the bench
  input  wire logic [3:0] channel_select_i,
  input  wire logic       convert_start_i,
  input  wire logic [3:0] delay_i,
  // result to the block
  output logic            convert_done_o,
  output logic [11:0]     result_o
);
  logic [3:0] count_reg;
  logic       run_reg;
  // result is only valid with done, so it toggles at all other times
  always_ff @(posedge clk_i) begin
    convert_done_o <= 1'b0;
    result_o <= ~result_o;
    if (rst_i) begin
      run_reg <= 1'b0;
      result_o <= 12'h5A5;
    end else if (convert_start_i) begin
      run_reg <= 1'b1;
      count_reg <= delay_i;
    end else if (run_reg && count_reg == 4'h0) begin
      run_reg <= 1'b0;
      convert_done_o <= 1'b1;
      result_o <= {channel_select_i, 8'h80};
    end else if (run_reg) begin
      count_reg <= count_reg - 4'h1;
    end
  end
endmodule : adc_core_model

// file: testbench/adc_seq_window_asserts.sv
`timescale 1ns/1ps
module adc_seq_window_asserts
  import adc_seq_window_pkg::*;
#(
  parameter int SETTLE_CYCLES = 2
) (
  // block ports, all observed
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [3:0]  channel_select_o,
  input wire logic        convert_start_o,
  input wire logic        convert_done_i,
  input wire logic [11:0] result_i,
  input wire logic        in_window_flag_o,
  input wire logic        above_upper_flag_o,
  input wire logic        below_lower_flag_o,
  input wire logic        busy_o,
  input wire logic        irq_o
);
  localparam int LAG_MIN = SETTLE_CYCLES;
  localparam int LAG_MAX = SETTLE_CYCLES + 2;
  logic [11:0] hi_q;
  logic [11:0] lo_q;
  logic        wr_q;
  assign wr_q = cyc_i && stb_i && we_i && !ack_o;
  // shadow thresholds; assumes whole-word writes as the bench makes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_q <= HIGH_THRESHOLD_RESET;
      lo_q <= LOW_THRESHOLD_RESET;
    end else if (wr_q && adr_i == OFFS_HIGH_THRESHOLD) begin
      hi_q <= dat_i[11:0];
    end else if (wr_q && adr_i == OFFS_LOW_THRESHOLD) begin
      lo_q <= dat_i[11:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_done; convert_done_i && busy_o; endsequence
  sequence s_go; wr_q && adr_i == OFFS_SEQ_CONTROL && dat_i[1:0] == 2'b01 && !busy_o; endsequence
  property p_ack; s_req |=> ack_o; endproperty
  property p_ack_drop; ack_o |=> !ack_o; endproperty
  property p_win; s_done |=> in_window_flag_o == ($past(result_i) >= lo_q && $past(result_i) < hi_q); endproperty
  property p_above; s_done |=> above_upper_flag_o == ($past(result_i) >= hi_q); endproperty
  property p_below; s_done |=> below_lower_flag_o == ($past(result_i) < lo_q); endproperty
  property p_hold; !convert_done_i |=> $stable({in_window_flag_o, above_upper_flag_o, below_lower_flag_o}); endproperty
  property p_go; s_go |=> busy_o; endproperty
  property p_lag; $rose(busy_o) |-> ##[LAG_MIN:LAG_MAX] convert_start_o; endproperty
  property p_chan; convert_start_o |-> $stable(channel_select_o) ##1 $stable(channel_select_o); endproperty
  property p_pulse; convert_start_o |=> !convert_start_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  a_win: assert property (p_win) else $error("in-window flag wrong");
  a_above: assert property (p_above) else $error("above flag wrong");
  a_below: assert property (p_below) else $error("below flag wrong");
  a_hold: assert property (p_hold) else $error("flags moved without result");
  a_go: assert property (p_go) else $error("start write ignored");
  a_lag: assert property (p_lag) else $error("conversion start late");
  a_chan: assert property (p_chan) else $error("channel moved at start");
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
endmodule : adc_seq_window_asserts

bind adc_sequence_and_window_cfg adc_seq_window_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .irq_o(irq_o),
  .channel_select_o(channel_select_o), .convert_start_o(convert_start_o),
  .convert_done_i(convert_done_i), .result_i(result_i), .in_window_flag_o(in_window_flag_o),
  .above_upper_flag_o(above_upper_flag_o), .below_lower_flag_o(below_lower_flag_o));

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adc_seq_window_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF, delay_i = 4'h0, channel_select_o;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [11:0] result_i;
  logic        ack_o, convert_start_o, convert_done_i, busy_o, irq_o;
  logic        in_window_flag_o, above_upper_flag_o, below_lower_flag_o;
  logic [3:0]  chans[$];
  int          mismatches = 0;
  int          total_checks = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (convert_start_o === 1'b1) chans.push_back(channel_select_o);
  adc_sequence_and_window_cfg #(.SETTLE_CYCLES(2)) i_adc_sequence_and_window_cfg (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .irq_o(irq_o),
    .channel_select_o(channel_select_o), .convert_start_o(convert_start_o),
    .convert_done_i(convert_done_i), .result_i(result_i), .in_window_flag_o(in_window_flag_o),
    .above_upper_flag_o(above_upper_flag_o), .below_lower_flag_o(below_lower_flag_o));
  adc_core_model i_adc_core_model (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay_i),
    .channel_select_i(channel_select_o), .convert_start_i(convert_start_o),
    .convert_done_o(convert_done_i), .result_o(result_i));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) check("ack", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic t_regs;
    wb(1'b0, OFFS_HIGH_THRESHOLD, 32'h0);
    check("high threshold reset", 32'h0000_0FFF, rd);
    wb(1'b0, OFFS_LOW_THRESHOLD, 32'h0);
    check("low threshold reset", 32'h0, rd);
    wb(1'b1, OFFS_HIGH_THRESHOLD, 32'h0000_0980);
    wb(1'b1, OFFS_LOW_THRESHOLD, 32'h0000_0480);
    wb(1'b0, OFFS_HIGH_THRESHOLD, 32'h0);
    check("high threshold", 32'h0000_0980, rd);
    wb(1'b0, OFFS_LOW_THRESHOLD, 32'h0);
    check("low threshold", 32'h0000_0480, rd);
    wb(1'b1, 8'h40, 32'h0000_00FF);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask : t_regs
  task automatic run_seq(input logic [31:0] lo_w, input logic [31:0] hi_w, input logic [3:0] d);
    logic [3:0]  c;
    logic [11:0] r;
    int          len;
    int          n;
    len = lo_w[18:16];
    n = 0;
    delay_i <= d;
    chans.delete();
    wb(1'b1, OFFS_SLOTS_LOW, lo_w);
    wb(1'b1, OFFS_SLOTS_HIGH, hi_w);
    wb(1'b0, OFFS_SLOTS_LOW, 32'h0);
    check("slots low", lo_w, rd);
    wb(1'b1, OFFS_SEQ_CONTROL, 32'h1);
    // a second start while running must not restart the scan
    wb(1'b1, OFFS_SEQ_CONTROL, 32'h1);
    while (busy_o !== 1'b0 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    check("slot count", len + 1, chans.size());
    for (int i = 0; i <= len; i++) begin
      c = (i < 4) ? lo_w[4*i +: 4] : hi_w[4*(i-4) +: 4];
      check("slot channel", {28'h0, c}, {28'h0, chans[i]});
    end
    r = {c, 8'h80};
    check("flags", {29'h0, r >= 12'h980, r >= 12'h480 && r < 12'h980, r < 12'h480},
      {29'h0, above_upper_flag_o, in_window_flag_o, below_lower_flag_o});
    wb(1'b0, OFFS_SEQ_STATUS, 32'h0);
    check("sequence status", {21'h0, 3'(len), 1'b0, r < 12'h480, r >= 12'h980,
      r >= 12'h480 && r < 12'h980, c}, rd);
  endtask : run_seq
  task automatic t_irq;
    wb(1'b1, OFFS_IRQ_MASK, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b0, OFFS_IRQ_STATUS, 32'h0);
    check("irq status", 32'h0000_000F, rd);
    wb(1'b1, OFFS_IRQ_MASK, 32'h8);
    wb(1'b0, OFFS_IRQ_MASK, 32'h0);
    check("irq mask", 32'h0000_0008, rd);
    check("irq raised", 32'h1, {31'h0, irq_o});
    wb(1'b1, OFFS_IRQ_STATUS, 32'h8);
    check("irq cleared", 32'h0, {31'h0, irq_o});
    wb(1'b0, OFFS_IRQ_STATUS, 32'h0);
    check("irq status cleared", 32'h0000_0007, rd);
  endtask : t_irq
  task automatic t_abort;
    delay_i <= 4'hF;
    wb(1'b1, OFFS_SEQ_CONTROL, 32'h1);
    repeat (4) @(posedge clk_i);
    wb(1'b1, OFFS_SEQ_CONTROL, 32'h2);
    check("busy after abort", 32'h0, {31'h0, busy_o});
    repeat (20) @(posedge clk_i);
  endtask : t_abort
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    run_seq(32'h0007_3210, 32'h0000_7654, 4'h0);
    run_seq(32'h0007_BA98, 32'h0000_FEDC, 4'h9);
    run_seq(32'h0000_0003, 32'h0000_FFFF, 4'h2);
    run_seq(32'h0004_1234, 32'h0000_0009, 4'h1);
    run_seq(32'h0001_0040, 32'h0000_0000, 4'h3);
    t_irq();
    t_abort();
    close_out();
  end
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
endmodule : tb_top
